// ---- pkg/enc_emu_pkg.sv ----
// Constants shared by the encoder output emulator
package enc_emu_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int UPDATE_US     = 250;
  localparam int UPDATE_CYC    = (UPDATE_US * 1000) / CLK_PERIOD_NS;
  localparam int MS_NS         = 1000000;
  localparam int MS_CYC        = MS_NS / CLK_PERIOD_NS;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_INTERP  = 8'h04;
  localparam logic [7:0] OFS_DIVISOR = 8'h08;
  localparam logic [7:0] OFS_PLIMIT  = 8'h0C;
  localparam logic [7:0] OFS_VLIMIT  = 8'h10;
  localparam logic [7:0] OFS_RIDE    = 8'h14;
  localparam logic [7:0] OFS_STATUS  = 8'h18;
  localparam logic [7:0] OFS_MASK    = 8'h1C;
  localparam logic [7:0] OFS_POS     = 8'h20;
  localparam logic [7:0] OFS_STATE   = 8'h24;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam logic [1:0] MODE_BUF = 2'h0;
  localparam logic [1:0] MODE_INT = 2'h1;
  localparam logic [1:0] MODE_DIV = 2'h2;
  localparam int CTRL_MODE_LSB    = 0;
  localparam int CTRL_FBTYPE_BIT  = 2;
  localparam int FINE_W           = 10;
  localparam logic [10:0] INTERP_MIN = 11'h004;
  localparam logic [10:0] INTERP_MAX = 11'h400;
  localparam logic [15:0] DIV_RST    = 16'h0001;
  localparam logic [31:0] PLIMIT_RST = 32'h00001F40;
  localparam logic [31:0] VLIMIT_RST = 32'h00100000;
  localparam logic [15:0] RIDE_RST   = 16'h0064;
  localparam int QUAD_SHIFT = 2;
  localparam int ST_POS = 0;
  localparam int ST_VEL = 1;
  localparam int ST_ILL = 2;
  localparam int ST_CFG = 3;
  localparam int ST_W   = 4;
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  typedef enum logic [2:0] {
    OUT_BUF = 3'b001,
    OUT_GEN = 3'b010,
    OUT_SRC = 3'b100
  } out_src_t;
endpackage

// ---- rtl/encoder_output_emulator.sv ----
// Encoder feedback decoder, quadrature output emulator and error faults
// Function
// [RULE1] Count on every edge of both channels: four counts per line.
// [RULE2] Position counts never leave on the connector, only quadrature.
// [RULE3] Buffered mode emits a filtered copy with equal cycles per rev.
// [RULE4] Incremental feedback: interpolated mode behaves as buffered.
// [RULE5] Divided incremental mode reduces emitted lines by the divisor.
// [RULE6] Sine/cosine cycles subdivide into up to 1024 counts.
// [RULE7] Sine/cosine buffered mode emits square quadrature, same cycles.
// [RULE8] Interpolation below four is rejected; four equals buffered.
// [RULE9] Divided sine/cosine output rate is interpolation over divisor.
// [RULE10] Loop position uses interpolation, never the output divisor.
// [RULE11] Output rate recomputed every 250 us, constant in between.
// [RULE12] Network-controlled variants offer buffered output only.
// [RULE13] Unbuffered outputs follow raw inputs, no filtering.
// [RULE14] Position fault when position error magnitude reaches limit.
// [RULE15] Velocity fault when velocity error magnitude reaches limit.
// [RULE16] Position fault only after limit held for ride-through ms.
// [RULE17] Direction from phase order; simultaneous transitions ignored.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
`timescale 1ns/1ps
module encoder_output_emulator #(
  parameter int UPDATE_CYC = enc_emu_pkg::UPDATE_CYC,
  parameter int MS_CYC     = enc_emu_pkg::MS_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        fb_a,
  input  wire logic        fb_b,
  input  wire logic [9:0]  sincos_fine_phase,
  input  wire logic        network_variant,
  input  wire logic [31:0] position_error,
  input  wire logic [31:0] velocity_error,
  output logic             unbuf_a,
  output logic             unbuf_b,
  output logic             quad_out_a,
  output logic             quad_out_b,
  output logic [31:0]      loop_position,
  output logic             excess_position_fault,
  output logic             excess_velocity_fault,
  output logic             irq
);
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] mag(input logic [31:0] v);
    mag = v[31] ? 32'(-v) : v;
  endfunction
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0]  be);
    for (int i = 0; i < 4; i++) begin
      old[8*i +: 8] = be[i] ? d[8*i +: 8] : old[8*i +: 8];
    end
    merge = old;
  endfunction

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ----------------------------------------
  // Input synchronisers and filter
  // ----------------------------------------
  logic [2:0] sa_reg;
  logic [2:0] sb_reg;
  logic       af_reg;
  logic       bf_reg;
  logic       a_edge;
  logic       b_edge;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sa_reg <= 3'h0;
      sb_reg <= 3'h0;
      af_reg <= 1'b0;
      bf_reg <= 1'b0;
    end else begin
      sa_reg <= {sa_reg[1:0], fb_a};
      sb_reg <= {sb_reg[1:0], fb_b};
      // A level counts only once two stages agree: rejects glitches
      if (sa_reg[1] == sa_reg[2]) af_reg <= sa_reg[2];
      if (sb_reg[1] == sb_reg[2]) bf_reg <= sb_reg[2];
    end
  end
  assign a_edge = (sa_reg[1] == sa_reg[2]) && (sa_reg[2] != af_reg);
  assign b_edge = (sb_reg[1] == sb_reg[2]) && (sb_reg[2] != bf_reg);

  // ----------------------------------------
  // Quadrature decoder
  // ----------------------------------------
  logic        [31:0] qcnt_reg;
  logic               count_up;
  logic               illegal;
  assign count_up = a_edge ? (sa_reg[2] ^ bf_reg) : ~(sb_reg[2] ^ af_reg); // RULE17
  assign illegal  = a_edge && b_edge; // RULE17
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      qcnt_reg <= 32'h0;
    end else if ((a_edge ^ b_edge)) begin // RULE1
      qcnt_reg <= count_up ? qcnt_reg + 32'h1 : qcnt_reg - 32'h1;
    end
  end

  sequence s_single_up;
    a_edge && !b_edge && count_up;
  endsequence
  a_quad_count: assert property (s_single_up |=> qcnt_reg == $past(qcnt_reg) + 32'h1) // RULE1
    else $error("count did not advance on a single edge");
  a_illegal_hold: assert property (illegal |=> $stable(qcnt_reg)) // RULE17
    else $error("simultaneous edges changed the count");

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  localparam int ST_W = enc_emu_pkg::ST_W;
  logic [1:0]       mode_reg;
  logic             fbtype_reg;
  logic [10:0]      interp_reg;
  logic [15:0]      div_reg;
  logic [31:0]      plimit_reg;
  logic [31:0]      vlimit_reg;
  logic [15:0]      ride_reg;
  logic [ST_W-1:0]  status_reg;
  logic [ST_W-1:0]  mask_reg;
  logic             net_reg;
  logic             net_done_reg;
  logic [7:0]       aw_addr_reg;
  logic [31:0]      w_data_reg;
  logic [3:0]       w_strb_reg;
  logic             wr_go;
  logic [31:0]      wr_val;
  logic             wr_map;
  logic             cfg_bad;

  assign wr_go = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  always_comb begin
    wr_val  = 32'h0;
    wr_map  = 1'b1;
    cfg_bad = 1'b0;
    case (aw_addr_reg)
      enc_emu_pkg::OFS_CTRL:    wr_val = merge({29'h0, fbtype_reg, mode_reg}, w_data_reg, w_strb_reg);
      enc_emu_pkg::OFS_INTERP:  begin
        wr_val  = merge({21'h0, interp_reg}, w_data_reg, w_strb_reg);
        cfg_bad = (wr_val < 32'(enc_emu_pkg::INTERP_MIN)) ||
                  (wr_val > 32'(enc_emu_pkg::INTERP_MAX)); // RULE8 RULE6
      end
      enc_emu_pkg::OFS_DIVISOR: begin
        wr_val  = merge({16'h0, div_reg}, w_data_reg, w_strb_reg);
        cfg_bad = (wr_val[15:0] == 16'h0);
      end
      enc_emu_pkg::OFS_PLIMIT:  wr_val = merge(plimit_reg, w_data_reg, w_strb_reg);
      enc_emu_pkg::OFS_VLIMIT:  wr_val = merge(vlimit_reg, w_data_reg, w_strb_reg);
      enc_emu_pkg::OFS_RIDE:    wr_val = merge({16'h0, ride_reg}, w_data_reg, w_strb_reg);
      enc_emu_pkg::OFS_STATUS:  wr_val = merge(32'h0, w_data_reg, w_strb_reg);
      enc_emu_pkg::OFS_MASK:    wr_val = merge({28'h0, mask_reg}, w_data_reg, w_strb_reg);
      enc_emu_pkg::OFS_POS, enc_emu_pkg::OFS_STATE: wr_val = 32'h0;
      default: wr_map = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_reg   <= enc_emu_pkg::MODE_BUF;
      fbtype_reg <= 1'b0;
      interp_reg <= enc_emu_pkg::INTERP_MIN;
      div_reg    <= enc_emu_pkg::DIV_RST;
      plimit_reg <= enc_emu_pkg::PLIMIT_RST;
      vlimit_reg <= enc_emu_pkg::VLIMIT_RST;
      ride_reg   <= enc_emu_pkg::RIDE_RST;
      mask_reg   <= '0;
    end else if (wr_go && !cfg_bad) begin
      case (aw_addr_reg)
        enc_emu_pkg::OFS_CTRL:    begin
          mode_reg   <= wr_val[enc_emu_pkg::CTRL_MODE_LSB +: 2];
          fbtype_reg <= wr_val[enc_emu_pkg::CTRL_FBTYPE_BIT];
        end
        enc_emu_pkg::OFS_INTERP:  interp_reg <= wr_val[10:0];
        enc_emu_pkg::OFS_DIVISOR: div_reg    <= wr_val[15:0];
        enc_emu_pkg::OFS_PLIMIT:  plimit_reg <= wr_val;
        enc_emu_pkg::OFS_VLIMIT:  vlimit_reg <= wr_val;
        enc_emu_pkg::OFS_RIDE:    ride_reg   <= wr_val[15:0];
        enc_emu_pkg::OFS_MASK:    mask_reg   <= wr_val[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // Variant strap is caught after reset release, then frozen
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      net_reg      <= 1'b0;
      net_done_reg <= 1'b0;
    end else if (!net_done_reg) begin
      net_reg      <= network_variant;
      net_done_reg <= 1'b1;
    end
  end

  a_interp_reject: assert property (
    wr_go && aw_addr_reg == enc_emu_pkg::OFS_INTERP && cfg_bad
    |=> $stable(interp_reg) && status_reg[enc_emu_pkg::ST_CFG]) // RULE8
    else $error("bad interpolation setting was accepted");

  // ----------------------------------------
  // Loop position
  // ----------------------------------------
  logic [31:0] cycles;
  logic [20:0] fine_prod;
  logic [31:0] loop_next;
  always_comb begin
    cycles    = 32'($signed(qcnt_reg) >>> enc_emu_pkg::QUAD_SHIFT);
    fine_prod = {11'h0, sincos_fine_phase} * {10'h0, interp_reg}; // RULE6
    // Divisor never enters here: the loops see full resolution
    loop_next = fbtype_reg ?
                32'(cycles * {21'h0, interp_reg}) + {21'h0, fine_prod[20:10]} :
                qcnt_reg; // RULE10
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) loop_position <= 32'h0;
    else          loop_position <= loop_next; // RULE10
  end

  // ----------------------------------------
  // Output rate generator
  // ----------------------------------------
  logic [31:0]       tick_cnt_reg;
  logic              tick;
  logic [31:0]       last_pos_reg;
  logic [31:0]       rate_reg;
  logic              dir_reg;
  logic [32:0]       acc_reg;
  logic [31:0]       thr;
  logic [31:0]       delta;
  logic              step;
  logic [1:0]        gq_reg;
  logic              gen_on;
  enc_emu_pkg::out_src_t src;

  // Network variants and x4 interpolated-mode settings fall back to the filtered copy
  assign gen_on = !net_reg && ((mode_reg == enc_emu_pkg::MODE_DIV) ||
                  (mode_reg == enc_emu_pkg::MODE_INT && fbtype_reg &&
                   interp_reg != enc_emu_pkg::INTERP_MIN)); // RULE12 RULE4 RULE8
  assign src    = gen_on ? enc_emu_pkg::OUT_GEN : enc_emu_pkg::OUT_BUF;
  assign tick   = (tick_cnt_reg == 32'(UPDATE_CYC - 1));
  assign thr    = (mode_reg == enc_emu_pkg::MODE_DIV) ?
                  32'(32'(UPDATE_CYC) * {16'h0, div_reg}) : 32'(UPDATE_CYC); // RULE5 RULE9
  assign delta  = loop_position - last_pos_reg;
  assign step   = (acc_reg >= {1'b0, thr});

  always_ff @(posedge aclk) begin
    if (!aresetn || tick) tick_cnt_reg <= 32'h0;
    else                  tick_cnt_reg <= tick_cnt_reg + 32'h1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      last_pos_reg <= 32'h0;
      rate_reg     <= 32'h0;
      dir_reg      <= 1'b1;
    end else if (tick) begin // RULE11
      last_pos_reg <= loop_position;
      // Capped so at most one edge per clock; excess is dropped, as last_pos_reg still takes the full position
      rate_reg     <= (mag(delta) > thr) ? thr : mag(delta);
      dir_reg      <= !delta[31];
    end
  end

  // Fractions carry across intervals until a direction reversal clears the accumulator
  always_ff @(posedge aclk) begin
    if (!aresetn || (tick && (dir_reg == delta[31]))) acc_reg <= 33'h0;
    else if (step) acc_reg <= acc_reg - {1'b0, thr} + {1'b0, rate_reg};
    else           acc_reg <= acc_reg + {1'b0, rate_reg};
  end

  // Phase tracks the filtered input while idle, so switching into the generated output never jumps
  always_ff @(posedge aclk) begin
    if (!aresetn) gq_reg <= 2'h0;
    else if (!gen_on) gq_reg <= {bf_reg, af_reg ^ bf_reg};
    else if (step) gq_reg <= dir_reg ? gq_reg + 2'h1 : gq_reg - 2'h1; // RULE9
  end

  // Only the A/B waveform reaches the connector pins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      quad_out_a <= 1'b0;
      quad_out_b <= 1'b0;
    end else begin
      case (src)
        enc_emu_pkg::OUT_GEN: begin
          // Forward motion: A leads B, as on the buffered copy
          quad_out_a <= gq_reg[1] ^ gq_reg[0];
          quad_out_b <= gq_reg[1]; // RULE2
        end
        default: begin
          quad_out_a <= af_reg; // RULE3 RULE7
          quad_out_b <= bf_reg;
        end
      endcase
    end
  end

  // Unbuffered path: one register stage, no filter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      unbuf_a <= 1'b0;
      unbuf_b <= 1'b0;
    end else begin
      unbuf_a <= fb_a; // RULE13
      unbuf_b <= fb_b;
    end
  end

  a_rate_hold: assert property (!tick |=> $stable(rate_reg)) // RULE11
    else $error("output rate changed between updates");
  a_buf_follow: assert property (!gen_on |=> quad_out_a == $past(af_reg)
                                 && quad_out_b == $past(bf_reg)) // RULE3
    else $error("buffered output does not follow filtered input");
  a_net_buffered: assert property (net_reg |=> quad_out_a == $past(af_reg)) // RULE12
    else $error("generated output enabled on network variant");
  a_unbuf_pass: assert property (##1 unbuf_a == $past(fb_a)) // RULE13
    else $error("unbuffered output not following input");

  // ----------------------------------------
  // Error faults
  // ----------------------------------------
  logic [31:0] ms_cnt_reg;
  logic        ms_tick;
  logic [15:0] pos_ms_reg;
  logic        pos_over;
  logic        vel_over;
  assign ms_tick  = (ms_cnt_reg == 32'(MS_CYC - 1));
  assign pos_over = (mag(position_error) >= plimit_reg); // RULE14
  assign vel_over = (mag(velocity_error) >= vlimit_reg); // RULE15

  always_ff @(posedge aclk) begin
    if (!aresetn || ms_tick) ms_cnt_reg <= 32'h0;
    else                     ms_cnt_reg <= ms_cnt_reg + 32'h1;
  end

  // Ride-through restarts whenever the error dips below the limit
  always_ff @(posedge aclk) begin
    if (!aresetn || !pos_over) pos_ms_reg <= 16'h0;
    else if (ms_tick && pos_ms_reg != 16'hFFFF) pos_ms_reg <= pos_ms_reg + 16'h1; // RULE16
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      excess_position_fault <= 1'b0;
      excess_velocity_fault <= 1'b0;
    end else begin
      excess_position_fault <= pos_over && (pos_ms_reg >= ride_reg); // RULE14 RULE16
      excess_velocity_fault <= vel_over; // RULE15
    end
  end

  sequence s_pos_held;
    pos_over && pos_ms_reg >= ride_reg;
  endsequence
  a_pos_fault_set: assert property (s_pos_held |=> excess_position_fault) // RULE14
    else $error("position fault missing after ride-through");
  a_pos_fault_ride: assert property (pos_ms_reg < ride_reg |=> !excess_position_fault) // RULE16
    else $error("position fault before ride-through elapsed");
  a_vel_fault: assert property (vel_over |=> excess_velocity_fault) // RULE15
    else $error("velocity fault missing at limit");

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  logic [ST_W-1:0] ev;
  logic [ST_W-1:0] clr;
  logic [ST_W-1:0] status_next;
  always_comb begin
    ev = '0;
    ev[enc_emu_pkg::ST_POS] = pos_over && (pos_ms_reg >= ride_reg) && !excess_position_fault;
    ev[enc_emu_pkg::ST_VEL] = vel_over && !excess_velocity_fault;
    ev[enc_emu_pkg::ST_ILL] = illegal;
    ev[enc_emu_pkg::ST_CFG] = wr_go && cfg_bad;
    clr = (wr_go && aw_addr_reg == enc_emu_pkg::OFS_STATUS) ? wr_val[ST_W-1:0] : '0;
    // New events win over a simultaneous clear
    status_next = (status_reg & ~clr) | ev;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      status_reg <= '0;
      irq        <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq        <= |(status_next & mask_reg);
    end
  end

  // ----------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------
  logic [31:0] rd_val;
  logic        rd_map;
  always_comb begin
    rd_map = 1'b1;
    case (s_axi_araddr)
      enc_emu_pkg::OFS_CTRL:    rd_val = {29'h0, fbtype_reg, mode_reg};
      enc_emu_pkg::OFS_INTERP:  rd_val = {21'h0, interp_reg};
      enc_emu_pkg::OFS_DIVISOR: rd_val = {16'h0, div_reg};
      enc_emu_pkg::OFS_PLIMIT:  rd_val = plimit_reg;
      enc_emu_pkg::OFS_VLIMIT:  rd_val = vlimit_reg;
      enc_emu_pkg::OFS_RIDE:    rd_val = {16'h0, ride_reg};
      enc_emu_pkg::OFS_STATUS:  rd_val = {28'h0, status_reg};
      enc_emu_pkg::OFS_MASK:    rd_val = {28'h0, mask_reg};
      enc_emu_pkg::OFS_POS:     rd_val = loop_position;
      enc_emu_pkg::OFS_STATE:   rd_val = {27'h0, net_reg, gen_on,
                                          excess_velocity_fault, excess_position_fault, 1'b0};
      default: begin
        rd_val = 32'h0;
        rd_map = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= enc_emu_pkg::RESP_OK;
      aw_addr_reg   <= 8'h00;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        s_axi_awready <= 1'b0;
        aw_addr_reg   <= {s_axi_awaddr[7:2], 2'h0};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        s_axi_wready <= 1'b0;
        w_data_reg   <= s_axi_wdata;
        w_strb_reg   <= s_axi_wstrb;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_map && !cfg_bad) ? enc_emu_pkg::RESP_OK : enc_emu_pkg::RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= enc_emu_pkg::RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_val;
      s_axi_rresp   <= rd_map ? enc_emu_pkg::RESP_OK : enc_emu_pkg::RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule

// ---- bench/quad_receiver.sv ----
// Quadrature receiver standing in for the external position controller
`timescale 1ns/1ps
module quad_receiver (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic qa,
  input  wire logic qb,
  output int        edges,
  output int        bad
);
  logic pa;
  logic pb;
  // Counts every edge on both lines, so cycles per rev can be compared
  always_ff @(posedge aclk) begin
    pa <= qa;
    pb <= qb;
    if (!aresetn) begin
      edges <= 0;
      bad   <= 0;
    end else begin
      edges <= edges + int'(qa != pa) + int'(qb != pb);
      // A controller cannot decode both lines moving at once
      if (qa != pa && qb != pb) begin
        bad <= bad + 1;
      end
    end
  end
endmodule

// ---- bench/test_encoder_output_emulator.sv ----
// Self-checking bench for the encoder output emulator
`timescale 1ns/1ps
module test_encoder_output_emulator;
  localparam int UPD = 50;
  localparam int MSC = 20;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic        s_axi_rready, fb_a, fb_b, network_variant, unbuf_a, unbuf_b, quad_out_a;
  logic        quad_out_b, excess_position_fault, excess_velocity_fault, irq, follow;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, position_error, velocity_error, loop_position;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [9:0]  sincos_fine_phase;
  int          num_errors, total_checks, cycles, edges, bad, e0, b0;

  encoder_output_emulator #(.UPDATE_CYC(UPD), .MS_CYC(MSC)) DUT (.aclk, .aresetn,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .fb_a, .fb_b, .sincos_fine_phase, .network_variant,
    .position_error, .velocity_error, .unbuf_a, .unbuf_b, .quad_out_a, .quad_out_b,
    .loop_position, .excess_position_fault, .excess_velocity_fault, .irq);
  quad_receiver ctrl (.aclk, .aresetn, .qa(quad_out_a), .qb(quad_out_b), .edges, .bad);

  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  // Hang guard: the whole sequence needs under a thousand cycles
  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid && !s_axi_awready) || (s_axi_wvalid && !s_axi_wready));
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    chk(s_axi_rdata, exp, "read data");
    chk(32'(s_axi_rresp), 32'(er), "read response");
    s_axi_rready <= 1'b0;
  endtask
  // One feedback state, held long enough for the input filter
  task automatic step(input logic a, input logic b);
    @(posedge aclk);
    fb_a <= a;
    fb_b <= b;
    repeat (8) @(posedge aclk);
    chk(32'({unbuf_a, unbuf_b}), 32'({a, b}), "unbuffered copy");
    if (follow) chk(32'({quad_out_a, quad_out_b}), 32'({a, b}), "buffered copy");
  endtask
  task automatic lines(input int n, input logic up);
    repeat (n) begin
      step(up, !up);
      step(1'b1, 1'b1);
      step(!up, up);
      step(1'b0, 1'b0);
    end
  endtask

  initial begin
    {num_errors, total_checks, cycles} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, position_error, velocity_error} = '0;
    {fb_a, fb_b, network_variant, sincos_fine_phase} = '0;
    s_axi_wstrb = 4'hF;
    follow = 1'b1;
    aresetn = 1'b0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(8'h04, 32'h00000004, 2'h0);
    rchk(8'h08, 32'h00000001, 2'h0);
    rchk(8'h0C, 32'h00001F40, 2'h0);
    rchk(8'h14, 32'h00000064, 2'h0);
    $display("test reset values done");
    lines(2, 1'b1);
    chk(loop_position, 32'h00000008, "forward count");
    lines(1, 1'b0);
    chk(loop_position, 32'h00000004, "reverse count");
    chk(32'(edges), 32'h0000000C, "emitted edges");
    wr(8'h00, 32'h00000001);
    lines(1, 1'b1);
    chk(loop_position, 32'h00000008, "interp count");
    wr(8'h00, 32'h00000005);
    lines(1, 1'b1);
    $display("test buffered paths done");
    wr(8'h18, 32'h0000000F);
    wr(8'h04, 32'h00000003);
    chk(32'(rs), 32'h2, "interp 3 refused");
    wr(8'h04, 32'h00000401);
    chk(32'(rs), 32'h2, "interp 1025 refused");
    wr(8'h08, 32'h00000000);
    chk(32'(rs), 32'h2, "divisor 0 refused");
    wr(8'h04, 32'h00000400);
    chk(32'(rs), 32'h0, "interp 1024 taken");
    rchk(8'h04, 32'h00000400, 2'h0);
    rchk(8'h18, 32'h00000008, 2'h0);
    rchk(8'h30, 32'h00000000, 2'h2);
    $display("test configuration done");
    wr(8'h00, 32'h00000000);
    wr(8'h18, 32'h0000000F);
    follow = 1'b0;
    step(1'b1, 1'b1);
    step(1'b0, 1'b0);
    chk(loop_position, 32'h0000000C, "illegal ignored");
    rchk(8'h18, 32'h00000004, 2'h0);
    wr(8'h1C, 32'h00000004);
    @(posedge aclk);
    chk(32'(irq), 32'h1, "irq raised");
    wr(8'h18, 32'h00000004);
    chk(32'(irq), 32'h0, "irq cleared");
    $display("test illegal transition done");
    wr(8'h14, 32'h00000002);
    position_error <= 32'h00001F40;
    repeat (10) @(posedge aclk);
    chk(32'(excess_position_fault), 32'h0, "ride-through");
    repeat (70) @(posedge aclk);
    chk(32'(excess_position_fault), 32'h1, "position fault");
    position_error <= 32'h00001F3F;
    velocity_error <= 32'hFFF00000;
    repeat (3) @(posedge aclk);
    chk(32'(excess_position_fault), 32'h0, "position fault gone");
    chk(32'(excess_velocity_fault), 32'h1, "velocity fault");
    velocity_error <= 32'hFFF00001;
    repeat (3) @(posedge aclk);
    chk(32'(excess_velocity_fault), 32'h0, "velocity fault gone");
    $display("test faults done");
    wr(8'h08, 32'h00000002);
    wr(8'h00, 32'h00000002);
    e0 = edges;
    b0 = bad;
    lines(4, 1'b1);
    repeat (6 * UPD) @(posedge aclk);
    chk(32'(edges - e0 >= 7 && edges - e0 <= 9), 32'h1, "divided edges");
    chk(32'(bad - b0), 32'h0, "clean quadrature");
    $display("test divided done");
    aresetn <= 1'b0;
    network_variant <= 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wr(8'h00, 32'h00000002);
    rchk(8'h24, 32'h00000010, 2'h0);
    $display("test network variant done");
    print_verdict();
  end
endmodule
